// ### src/ssie_engine.sv
// serial shift-in engine: master clock generation, sampling and assembly
`timescale 1ns/1ps
module ssie_engine (
   input wire logic clk,
   input wire logic reset,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic [2:0] req_mode,
   input wire logic [ssie_pkg::CNT_W-1:0] req_count,
   input wire logic req_count_given,
   input wire logic req_last,
   input wire logic [ssie_pkg::PHASE_W-1:0] phase_idle_len,
   input wire logic [ssie_pkg::PHASE_W-1:0] phase_active_len,
   input wire logic sdata_i,
   output logic sdata_o,
   output logic sdata_oe,
   output logic sclk_o,
   output logic sclk_oe,
   output logic busy,
   output logic [ssie_pkg::MAX_BITS-1:0] result_data,
   output logic result_valid,
   output logic result_last
);
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_LEAD,
      ST_ACT,
      ST_TRAIL,
      ST_NEXT
   } ssie_state_e;

   typedef struct packed {
      ssie_state_e state;
      logic [2:0] mode;
      logic [ssie_pkg::CNT_W-1:0] nbits;
      logic [ssie_pkg::CNT_W-1:0] bitcnt;
      logic last;
      logic [ssie_pkg::MAX_BITS-1:0] shreg;
      logic req_ready;
      logic sclk;
      logic sclk_oe;
      logic busy;
      logic [ssie_pkg::MAX_BITS-1:0] result_data;
      logic result_valid;
      logic result_last;
   } ssie_engine_s;

   ssie_engine_s s;
   ssie_engine_s next_s;
   logic sd;
   logic timer_load;
   logic [ssie_pkg::PHASE_W-1:0] timer_len;
   logic timer_expired;
   logic capture;
   logic [ssie_pkg::MAX_BITS-1:0] sampled;

   ssie_sync u_sync (
      .clk(clk),
      .reset(reset),
      .pin(sdata_i),
      .level(sd)
   );

   ssie_phase_timer #(.WIDTH(ssie_pkg::PHASE_W)) u_timer (
      .clk(clk),
      .reset(reset),
      .load(timer_load),
      .len(timer_len),
      .expired(timer_expired)
   );

   function automatic logic [ssie_pkg::CNT_W-1:0] pick_count(
      input logic given,
      input logic [ssie_pkg::CNT_W-1:0] cnt
   );
      logic [ssie_pkg::CNT_W-1:0] r;
      r = ssie_pkg::DEF_BITS;
      if (given && cnt != '0) begin
         r = (cnt > ssie_pkg::FULL_BITS) ? ssie_pkg::FULL_BITS : cnt;
      end
      return r;
   endfunction : pick_count

   // insert the captured bit according to the bit order
   always_comb begin
      if (s.mode[ssie_pkg::MODE_LOW_FIRST]) begin
         sampled = {sd, s.shreg[ssie_pkg::MAX_BITS-1:1]};
      end else begin
         sampled = {s.shreg[ssie_pkg::MAX_BITS-2:0], sd};
      end
   end

   always_comb begin
      logic done_bit;
      logic [ssie_pkg::CNT_W-1:0] nxt_cnt;
      done_bit = 1'b0;
      nxt_cnt = ssie_pkg::CNT_W'(s.bitcnt + 1'b1);
      next_s = s;
      next_s.result_valid = 1'b0;
      timer_load = 1'b0;
      timer_len = phase_idle_len;
      capture = 1'b0;
      case (s.state)
         ST_IDLE: begin
            if (req_valid) begin
               next_s.mode = req_mode;
               next_s.sclk = req_mode[ssie_pkg::MODE_IDLE_HIGH];
               next_s.sclk_oe = 1'b1;
               next_s.nbits = pick_count(req_count_given, req_count);
               next_s.last = req_last;
               next_s.bitcnt = '0;
               next_s.shreg = '0;
               next_s.busy = 1'b1;
               next_s.req_ready = 1'b0;
               timer_load = 1'b1;
               next_s.state = ST_LEAD;
            end
         end
         ST_NEXT: begin
            // link held at idle level between results of one transfer
            if (req_valid) begin
               next_s.nbits = pick_count(req_count_given, req_count);
               next_s.last = req_last;
               next_s.bitcnt = '0;
               next_s.shreg = '0;
               next_s.req_ready = 1'b0;
               timer_load = 1'b1;
               next_s.state = ST_LEAD;
            end
         end
         ST_LEAD: begin
            if (timer_expired) begin
               if (!s.mode[ssie_pkg::MODE_LATE]) begin
                  capture = 1'b1;
                  next_s.shreg = sampled;
               end
               next_s.sclk = ~s.mode[ssie_pkg::MODE_IDLE_HIGH];
               timer_len = phase_active_len;
               timer_load = 1'b1;
               next_s.state = ST_ACT;
            end
         end
         ST_ACT: begin
            if (timer_expired) begin
               next_s.sclk = s.mode[ssie_pkg::MODE_IDLE_HIGH];
               if (s.mode[ssie_pkg::MODE_LATE]) begin
                  timer_load = 1'b1;
                  next_s.state = ST_TRAIL;
               end else begin
                  done_bit = 1'b1;
               end
            end
         end
         ST_TRAIL: begin
            if (timer_expired) begin
               capture = 1'b1;
               next_s.shreg = sampled;
               done_bit = 1'b1;
            end
         end
         default: begin
            next_s.state = ST_IDLE;
         end
      endcase
      if (done_bit) begin
         next_s.bitcnt = nxt_cnt;
         if (nxt_cnt == s.nbits) begin
            next_s.result_valid = 1'b1;
            next_s.result_last = s.last;
            // low-first leaves the bits at the top; move them down
            if (s.mode[ssie_pkg::MODE_LOW_FIRST]) begin
               next_s.result_data = next_s.shreg >> (ssie_pkg::FULL_BITS - s.nbits);
            end else begin
               next_s.result_data = next_s.shreg;
            end
            next_s.req_ready = 1'b1;
            next_s.busy = !s.last;
            next_s.state = s.last ? ST_IDLE : ST_NEXT;
         end else begin
            timer_load = 1'b1;
            next_s.state = ST_LEAD;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s <= '0;
         s.state <= ST_IDLE;
         s.req_ready <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign req_ready = s.req_ready;
   assign sclk_o = s.sclk;
   assign sclk_oe = s.sclk_oe;
   // the data line is only ever listened to
   assign sdata_o = 1'b0;
   assign sdata_oe = 1'b0;
   assign busy = s.busy;
   assign result_data = s.result_data;
   assign result_valid = s.result_valid;
   assign result_last = s.result_last;

   // helper: length of the current active clock phase
   logic [ssie_pkg::PHASE_W:0] act_cnt;
   logic clk_active;
   assign clk_active = s.sclk_oe && (s.sclk != s.mode[ssie_pkg::MODE_IDLE_HIGH]);
   always_ff @(posedge clk) begin
      if (reset) begin
         act_cnt <= '0;
      end else if (clk_active) begin
         act_cnt <= (ssie_pkg::PHASE_W+1)'(act_cnt + 1'b1);
      end else begin
         act_cnt <= '0;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   property p_data_input;
      sdata_oe == 1'b0;
   endproperty
   a_data_input: assert property (p_data_input) else $error("data line driven");

   property p_start_idle;
      (s.state == ST_IDLE && req_valid) |=>
         (sclk_oe && sclk_o == $past(req_mode[2]) && busy);
   endproperty
   a_start_idle: assert property (p_start_idle) else $error("bad clock at start");

   property p_quiet_idle;
      (!busy && $past(!busy)) |-> $stable(sclk_o);
   endproperty
   a_quiet_idle: assert property (p_quiet_idle) else $error("clock moved when idle");

   property p_last_ends;
      (result_valid && result_last) |-> (!busy && req_ready && s.state == ST_IDLE);
   endproperty
   a_last_ends: assert property (p_last_ends) else $error("transfer not closed");

   property p_default_count;
      ((s.state == ST_IDLE || s.state == ST_NEXT) && req_valid
         && (!req_count_given || req_count == 5'h00)) |=> (s.nbits == 5'h08);
   endproperty
   a_default_count: assert property (p_default_count) else $error("default not 8");

   property p_active_len;
      ($past(clk_active) && !clk_active && $past(s.sclk_oe)) |->
         ($past(act_cnt) + 1 == (($past(phase_active_len) == 0) ? 1 : $past(phase_active_len)));
   endproperty
   a_active_len: assert property (p_active_len) else $error("active phase length");

   property p_insert;
      capture |=> (s.mode[0] ? s.shreg[15] == $past(sd) : s.shreg[0] == $past(sd));
   endproperty
   a_insert: assert property (p_insert) else $error("bit inserted at wrong end");

   property p_sample_time;
      capture |-> (s.mode[1] ? (s.state == ST_TRAIL) : (s.state == ST_LEAD))
         && (sclk_o == s.mode[2]);
   endproperty
   a_sample_time: assert property (p_sample_time) else $error("sample at wrong time");

   property p_hold_link;
      (s.state == ST_NEXT) |-> (busy && sclk_oe && sclk_o == s.mode[2]);
   endproperty
   a_hold_link: assert property (p_hold_link) else $error("link released");

   property p_valid_pulse;
      result_valid |=> !result_valid;
   endproperty
   a_valid_pulse: assert property (p_valid_pulse) else $error("result strobe too long");

   property p_bit_count;
      result_valid |-> (s.bitcnt == s.nbits);
   endproperty
   a_bit_count: assert property (p_bit_count) else $error("result before count reached");

   property p_busy_shift;
      (s.state == ST_LEAD || s.state == ST_ACT || s.state == ST_TRAIL) |-> (busy && !req_ready);
   endproperty
   a_busy_shift: assert property (p_busy_shift) else $error("ready while shifting");

   property p_idle_phase;
      (s.state == ST_LEAD || s.state == ST_TRAIL) |-> (sclk_oe && sclk_o == s.mode[2]);
   endproperty
   a_idle_phase: assert property (p_idle_phase) else $error("clock away from idle");

   property p_active_phase;
      (s.state == ST_ACT) |-> (sclk_oe && sclk_o != s.mode[2]);
   endproperty
   a_active_phase: assert property (p_active_phase) else $error("no clock pulse");

   // counts above the widest result are clamped rather than refused
   property p_given_count;
      ((s.state == ST_IDLE || s.state == ST_NEXT) && req_valid && req_count_given
         && req_count != 5'h00) |=>
         (s.nbits == (($past(req_count) > 5'h10) ? 5'h10 : $past(req_count)));
   endproperty
   a_given_count: assert property (p_given_count) else $error("count not taken");

   property p_right_aligned;
      result_valid |-> ((result_data >> s.nbits) == 16'h0000);
   endproperty
   a_right_aligned: assert property (p_right_aligned) else $error("result misaligned");

   c_single: cover property (result_valid && result_last && s.nbits == 5'h10);
   c_low_first_high_idle: cover property (result_valid && s.mode == 3'h7);
   c_chain: cover property (result_valid && !result_last ##[1:1000] result_valid);
   c_late_default: cover property (result_valid && s.mode[1] && s.nbits == 5'h08);
endmodule : ssie_engine

// ### src/ssie_phase_timer.sv
// down-counter that times one clock phase in system clock cycles
`timescale 1ns/1ps
module ssie_phase_timer #(
   parameter int unsigned WIDTH = 8
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic load,
   input wire logic [WIDTH-1:0] len,
   output logic expired
);
   typedef struct packed {
      logic run;
      logic [WIDTH-1:0] count;
   } ssie_timer_s;

   ssie_timer_s s;
   ssie_timer_s next_s;

   always_comb begin
      next_s = s;
      if (load) begin
         next_s.run = 1'b1;
         // zero length is treated as one cycle so a phase never vanishes
         next_s.count = (len == '0) ? '0 : WIDTH'(len - 1'b1);
      end else if (s.run && s.count == '0) begin
         next_s.run = 1'b0;
      end else if (s.run) begin
         next_s.count = WIDTH'(s.count - 1'b1);
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign expired = s.run && (s.count == '0);
endmodule : ssie_phase_timer

// ### src/ssie_pkg.sv
// constants shared by the serial shift-in engine
// Functional notes
// - mode code 0..7: bit0 low-first, bit1 sample late, bit2 clock idles high
// - on transfer start the clock line becomes an output at its idle level
// - data line is made an input at start and stays an input afterwards
// - early modes capture data before the pulse, late modes after it
// - each bit gets exactly one clock pulse away from idle and back
// - high-first inserts at low end shifting left, low-first at high end right
// - high-first: first received bit lands in the result's top position
// - repeat sample, pulse, shift until the count is reached, then signal done
// - per-result count is 1 to 16, defaulting to 8 when none is given
// - several results with own counts follow back to back, link held
// - single-result form: count given with request, value returned directly
package ssie_pkg;
   localparam int unsigned MAX_BITS = 16;
   localparam int unsigned CNT_W = 5;
   localparam int unsigned PHASE_W = 8;
   localparam logic [CNT_W-1:0] DEF_BITS = 5'h08;
   localparam logic [CNT_W-1:0] FULL_BITS = 5'h10;
   localparam int unsigned MODE_LOW_FIRST = 0;
   localparam int unsigned MODE_LATE = 1;
   localparam int unsigned MODE_IDLE_HIGH = 2;
   localparam logic [2:0] HIGH_FIRST_SAMPLE_EARLY = 3'h0;
   localparam logic [2:0] LOW_FIRST_SAMPLE_EARLY = 3'h1;
   localparam logic [2:0] HIGH_FIRST_SAMPLE_LATE = 3'h2;
   localparam logic [2:0] LOW_FIRST_SAMPLE_LATE = 3'h3;
   localparam logic [2:0] HIGH_FIRST_EARLY_IDLE_HIGH = 3'h4;
   localparam logic [2:0] LOW_FIRST_EARLY_IDLE_HIGH = 3'h5;
   localparam logic [2:0] HIGH_FIRST_LATE_IDLE_HIGH = 3'h6;
   localparam logic [2:0] LOW_FIRST_LATE_IDLE_HIGH = 3'h7;
   localparam logic [PHASE_W-1:0] PHASE_RESET = 8'h00;
endpackage : ssie_pkg

// ### src/ssie_sync.sv
// three-flop synchroniser with agreement filter for the data pin
`timescale 1ns/1ps
module ssie_sync (
   input wire logic clk,
   input wire logic reset,
   input wire logic pin,
   output logic level
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic out;
   } ssie_sync_s;

   ssie_sync_s s;
   ssie_sync_s next_s;

   always_comb begin
      next_s = s;
      next_s.s1 = pin;
      next_s.s2 = s.s1;
      next_s.s3 = s.s2;
      // a change only counts once the later two stages agree
      if (s.s2 == s.s3) begin
         next_s.out = s.s3;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign level = s.out;
endmodule : ssie_sync

// ### tb/ssie_periph.sv
// behavioural serial peripheral shifting a preset bit stream onto the data pin
`timescale 1ns/1ps
module ssie_periph (
   input wire logic clk,
   input wire logic start,
   input wire logic late,
   input wire logic idle_high,
   input wire logic [63:0] stream,
   input wire logic sclk,
   output logic sdata
);
   logic prev = 1'b0;
   logic armed = 1'b0;
   logic [6:0] idx = 7'h00;
   // edges toward idle without a leading edge first are mode switches, not pulses
   // the falling edge keeps the model clear of the engine's own clock edge
   always @(negedge clk) begin
      prev <= sclk;
      if (start) begin
         idx <= 7'h00;
         armed <= 1'b0;
      end else if (prev === idle_high && sclk === ~idle_high) begin
         armed <= 1'b1;
         if (late) idx <= idx + 7'h01;
      end else if (armed && prev === ~idle_high && sclk === idle_high) begin
         armed <= 1'b0;
         if (!late) idx <= idx + 7'h01;
      end
   end
   // before the first leading edge a late-mode pin shows the wrong level on purpose
   always_comb begin
      if (late && idx == 7'h00) sdata = ~stream[0];
      else if (late) sdata = stream[idx - 7'h01];
      else sdata = stream[idx];
   end
endmodule : ssie_periph

// ### tb/tb_serial_shift_in_engine.sv
// self-checking bench for the serial shift-in engine against a bit-stream model
`timescale 1ns/1ps
module tb_serial_shift_in_engine;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic req_valid = 1'b0;
   logic req_ready;
   logic [2:0] req_mode = 3'h0;
   logic [ssie_pkg::CNT_W-1:0] req_count = 5'h00;
   logic req_count_given = 1'b0;
   logic req_last = 1'b0;
   logic [ssie_pkg::PHASE_W-1:0] phase_idle_len = 8'h06;
   logic [ssie_pkg::PHASE_W-1:0] phase_active_len = 8'h01;
   logic sdata_i, sdata_o, sdata_oe, sclk_o, sclk_oe, busy, result_valid, result_last;
   logic [ssie_pkg::MAX_BITS-1:0] result_data;
   logic start = 1'b0;
   logic [63:0] stream = 64'h0;
   logic [2:0] cur_mode = 3'h0;
   logic sclk_prev = 1'b0;
   int fails = 0;
   int comparisons = 0;
   int pulses = 0;
   int pos = 0;

   ssie_engine DUT (.clk(clk), .reset(reset), .req_valid(req_valid), .req_ready(req_ready),
      .req_mode(req_mode), .req_count(req_count), .req_count_given(req_count_given),
      .req_last(req_last), .phase_idle_len(phase_idle_len),
      .phase_active_len(phase_active_len), .sdata_i(sdata_i), .sdata_o(sdata_o),
      .sdata_oe(sdata_oe), .sclk_o(sclk_o), .sclk_oe(sclk_oe), .busy(busy),
      .result_data(result_data), .result_valid(result_valid), .result_last(result_last));

   ssie_periph PERIPH (.clk(clk), .start(start), .late(cur_mode[1]), .idle_high(cur_mode[2]),
      .stream(stream), .sclk(sclk_o), .sdata(sdata_i));

   // only moves away from idle count, so mode switches between transfers are ignored
   always @(negedge clk) begin
      sclk_prev <= sclk_o;
      if (sclk_prev === cur_mode[2] && sclk_o === ~cur_mode[2]) pulses <= pulses + 1;
   end

   task automatic conclude();
      $display("comparisons=%0d fails=%0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic rest_chk();
      chk({req_ready, busy, sclk_oe, sclk_o, result_valid, result_last}, 32'h20);
      chk(result_data, 32'h0);
   endtask : rest_chk

   task automatic setup(input logic [2:0] mode);
      cur_mode = mode;
      stream = {$urandom, $urandom};
      pos = 0;
      phase_idle_len = 8'($urandom_range(8, 6));
      phase_active_len = 8'($urandom_range(3, 1));
   endtask : setup

   task automatic xfer(input int n, input logic given, input logic last, input logic [2:0] mode,
      input logic first);
      int eff;
      int cyc;
      int expc;
      logic [31:0] exp;
      eff = (given && n != 0) ? n : 8;
      exp = 32'h0;
      for (int i = 0; i < eff; i++) begin
         if (cur_mode[0]) exp[i] = stream[pos + i];
         else exp = {exp[30:0], stream[pos + i]};
      end
      // the strobe is registered on the edge that closes the last phase
      expc = eff * (phase_idle_len + phase_active_len);
      if (cur_mode[1]) expc = expc + eff * phase_idle_len;
      req_mode = mode;
      req_count = 5'(n);
      req_count_given = given;
      req_last = last;
      req_valid = 1'b1;
      cyc = 0;
      // ready is read between edges; the take is the edge after it is seen
      while (req_ready !== 1'b1 && cyc < 2000) begin
         @(posedge clk);
         #1;
         cyc++;
      end
      if (req_ready !== 1'b1) begin
         fails++;
         conclude();
      end
      @(posedge clk);
      #1;
      req_valid = 1'b0;
      pulses = 0;
      start = first;
      @(posedge clk);
      #1;
      start = 1'b0;
      cyc = 1;
      chk(busy, 1'b1);
      do begin
         @(posedge clk);
         #1;
         cyc++;
      end while (result_valid !== 1'b1 && cyc < 3000);
      if (result_valid !== 1'b1) begin
         fails++;
         conclude();
      end
      chk(cyc, expc);
      chk(result_data, exp);
      chk(pulses, eff);
      chk(sclk_o, cur_mode[2]);
      chk({sclk_oe, sdata_oe, sdata_o}, 3'h4);
      chk(req_ready, 1'b1);
      chk(result_last, last);
      pos = pos + eff;
   endtask : xfer

   initial begin
      forever #5 clk = ~clk;
   end

   initial begin
      void'($urandom(45));
      repeat (4) @(posedge clk);
      #1;
      reset = 1'b0;
      rest_chk();
      for (int rep = 0; rep < 2; rep++) begin
         for (int m = 0; m < 8; m++) begin
            setup(3'(m));
            xfer(rep == 0 ? $urandom_range(16, 1) : (m[0] ? 16 : 1), 1'b1, 1'b1,
               3'(m), 1'b1);
         end
      end
      // a reset between transfers must bring every output back to rest
      reset = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      reset = 1'b0;
      rest_chk();
      // later results carry a random mode that the engine must ignore
      for (int k = 0; k < 3; k++) begin
         setup(3'($urandom));
         xfer(5, 1'b1, 1'b0, cur_mode, 1'b1);
         xfer(9, 1'b0, 1'b0, 3'($urandom), 1'b0);
         xfer(0, 1'b1, 1'b0, 3'($urandom), 1'b0);
         xfer(16, 1'b1, 1'b1, 3'($urandom), 1'b0);
      end
      conclude();
   end
endmodule : tb_serial_shift_in_engine
